// [test/motion_sensor_data_and_control_regs_tb.sv]
/*
  Self-checking bench for the motion sensor register block.
  Assumes the host model and checker; inputs change on the falling edge.
*/
`timescale 1ns/1ns
`include "msdc_regs.svh"
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin mismatches++; \
  $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp); end end
module motion_sensor_data_and_control_regs_tb;
  import msdc_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  msdc_reg_req_t req;
  msdc_sample_t sample = '0;
  msdc_sample_t s;
  msdc_sample_t s1;
  logic sample_valid = 1'b0;
  logic src_en = 1'b0;
  logic [7:0] thr = 8'h00;
  logic [7:0] rdata, rv, hi, lo, buf_wdata;
  logic rvalid, md_hit, buf_ser, two_wire_dis, buf_rst, buf_wr, hit;
  logic [127:0] r;
  int mismatches = 0;
  int samples_checked = 0;
  int n, dps;
  integer seed = 32'h3A58;
  // free-running 100 MHz clock
  always #5 ref_clk_in = ~ref_clk_in;
  msdc_regs_top uut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .reg_req_in(req),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .sample_in(sample),
    .sample_valid_in(sample_valid), .accel_buf_src_en_in(src_en), .wom_threshold_in(thr),
    .accel_path_rst_out(), .temp_path_rst_out(), .rate_path_rst_out(),
    .motion_detect_enable_out(), .motion_detect_mode_out(), .motion_detected_out(md_hit),
    .buf_serial_en_out(buf_ser), .two_wire_interface_disable_out(two_wire_dis),
    .buf_rst_out(buf_rst), .buf_wr_out(buf_wr), .buf_wdata_out(buf_wdata));
  msdc_host_model host (.ref_clk_in(ref_clk_in), .reg_req_out(req), .reg_rdata_in(rdata),
    .reg_rvalid_in(rvalid));
  // expected byte of a result set at a result address, odd address is the upper byte
  function automatic logic [7:0] exp_byte(msdc_sample_t v, logic [7:0] a);
    logic [15:0] w;
    w = v[111 - 16 * ((int'(a) - int'(`MSDC_RESULT_FIRST)) >> 1) -: 16];
    return a[0] ? w[15:8] : w[7:0];
  endfunction
  task automatic end_test(string name);
    $display("test %s done", name);
  endtask
  // one sample tick; the motion flag stands in the following cycle
  task automatic put_sample(msdc_sample_t v, output logic flag);
    @(negedge ref_clk_in);
    sample = v;
    sample_valid = 1'b1;
    @(negedge ref_clk_in);
    flag = md_hit;
    sample_valid = 1'b0;
    sample = ~v;
  endtask
  task automatic check_results(msdc_sample_t v);
    for (int a = `MSDC_RESULT_FIRST; a <= `MSDC_RESULT_LAST; a++) begin
      host.rd_reg(8'(a), rv);
      `CHK(rv, exp_byte(v, 8'(a)))
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // watchdog: the sequence needs a few hundred cycles, this allows tens of thousands
  initial begin
    #400000;
    mismatches++;
    finish_test();
  end
  initial begin
    repeat (5) @(negedge ref_clk_in);
    rst_n_in = 1'b1;
    host.rd_reg(`MSDC_HOST_CONTROL, rv);
    `CHK(rv, `MSDC_HOST_CONTROL_RST)
    check_results('0);
    end_test("reset");
    // random result sets with a known angular rate and random host pacing
    for (int i = 0; i < 5; i++) begin
      r = {$random(seed), $random(seed), $random(seed), $random(seed)};
      s = r[111:0];
      dps = $random(seed) % 251;
      s.rate_x = 16'(dps * `MSDC_RATE_COUNTS_PER_DPS);
      host.gap = $random(seed) & 3;
      thr = r[127:120];
      put_sample(s, hit);
      check_results(s);
      host.rd_reg(`MSDC_RATE_X_HIGH_BYTE, hi);
      host.rd_reg(`MSDC_RATE_X_LOW_BYTE, lo);
      `CHK({hi, lo}, 16'(dps * `MSDC_RATE_COUNTS_PER_DPS))
    end
    host.gap = 0;
    // low byte is held from the upper-byte read across a new sample
    s1 = s;
    host.rd_reg(`MSDC_RATE_Y_HIGH_BYTE, rv);
    s.rate_y = ~s.rate_y;
    put_sample(s, hit);
    host.rd_reg(`MSDC_RATE_Y_LOW_BYTE, rv);
    `CHK(rv, s1.rate_y[7:0])
    host.rd_reg(`MSDC_RATE_Y_LOW_BYTE, rv);
    `CHK(rv, s.rate_y[7:0])
    host.wr_reg(`MSDC_ACCEL_X_HIGH_BYTE, ~s.accel_x[15:8]);
    host.rd_reg(`MSDC_ACCEL_X_HIGH_BYTE, rv);
    `CHK(rv, s.accel_x[15:8])
    host.rd_reg(8'h00, rv);
    `CHK(rv, 8'h00)
    host.wr_reg(`MSDC_PATH_RESET_CONTROL, 8'hFF);
    host.rd_reg(`MSDC_PATH_RESET_CONTROL, rv);
    `CHK(rv, 8'h00)
    check_results(s);
    end_test("results");
    host.wr_reg(`MSDC_HOST_CONTROL, 8'hFE);
    host.rd_reg(`MSDC_HOST_CONTROL, rv);
    `CHK(rv, 8'h54)
    `CHK({buf_ser, two_wire_dis}, 2'b11)
    repeat (6) @(negedge ref_clk_in);
    host.wr_reg(`MSDC_HOST_CONTROL, 8'h04);
    n = 0;
    repeat (10) begin
      n += buf_rst;
      @(negedge ref_clk_in);
    end
    `CHK(n, `MSDC_BUF_RST_CYC)
    host.rd_reg(`MSDC_HOST_CONTROL, rv);
    `CHK(rv, 8'h00)
    // buffer stream runs with serial buffer access switched off
    src_en = 1'b1;
    put_sample(s, hit);
    n = 0;
    repeat (8) begin
      @(negedge ref_clk_in);
      if (buf_wr === 1'b1) begin
        `CHK(buf_wdata, exp_byte(s, 8'(`MSDC_RESULT_FIRST + n)))
        n++;
      end
    end
    `CHK(n, `MSDC_ACCEL_BUF_BYTES)
    src_en = 1'b0;
    host.wr_reg(`MSDC_MOTION_DETECT_CONTROL, 8'hFF);
    host.rd_reg(`MSDC_MOTION_DETECT_CONTROL, rv);
    `CHK(rv, 8'hC0)
    // threshold one: a step of 511 is quiet, 512 is flagged
    thr = 8'h01;
    s.accel_z = 16'h0000;
    put_sample(s, hit);
    s.accel_z = 16'h01FF;
    put_sample(s, hit);
    `CHK(hit, 1'b0)
    s.accel_z = 16'h03FF;
    put_sample(s, hit);
    `CHK(hit, 1'b1)
    host.wr_reg(`MSDC_MOTION_DETECT_CONTROL, 8'h40);
    s.accel_z = 16'h0000;
    put_sample(s, hit);
    `CHK(hit, 1'b0)
    host.wr_reg(`MSDC_HOST_CONTROL, 8'h01);
    check_results('0);
    end_test("control");
    finish_test();
  end
endmodule

// [test/msdc_host_model.sv]
/*
  Host model issuing single-cycle register accesses to the register block.
  Assumes the block answers a read exactly one cycle after the request edge.
*/
`timescale 1ns/1ns
module msdc_host_model (
  // clock
  input wire logic ref_clk_in,
  // register access toward the block
  output msdc_pkg::msdc_reg_req_t reg_req_out,
  input wire logic [7:0] reg_rdata_in,
  input wire logic reg_rvalid_in
);
  import msdc_pkg::*;
  int gap = 0;
  initial reg_req_out = '0;
  // idle bus shows inverted fields so stale values never pass for live ones
  task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
    repeat (gap) @(negedge ref_clk_in);
    @(negedge ref_clk_in);
    reg_req_out = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(negedge ref_clk_in);
    reg_req_out = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
  endtask
  // read data stands only in the cycle after the request edge
  task automatic rd_reg(input logic [7:0] addr, output logic [7:0] data);
    repeat (gap) @(negedge ref_clk_in);
    @(negedge ref_clk_in);
    reg_req_out = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
    @(negedge ref_clk_in);
    data = reg_rvalid_in ? reg_rdata_in : 8'hXX;
    reg_req_out = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: 8'hFF};
  endtask
endmodule

// [test/msdc_regs_top_asserts.sv]
/*
  Checker for the motion sensor register block, bound onto msdc_regs_top.
  Assumes only the top module's ports and the constants of msdc_regs.svh.
*/
`timescale 1ns/1ns
`include "msdc_regs.svh"
module msdc_regs_chk (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // watched inputs
  input wire msdc_pkg::msdc_reg_req_t reg_req_in,
  input wire msdc_pkg::msdc_sample_t sample_in,
  input wire logic sample_valid_in,
  input wire logic accel_buf_src_en_in,
  // watched outputs
  input wire logic reg_rvalid_out,
  input wire logic accel_path_rst_out,
  input wire logic temp_path_rst_out,
  input wire logic rate_path_rst_out,
  input wire logic motion_detect_enable_out,
  input wire logic motion_detect_mode_out,
  input wire logic motion_detected_out,
  input wire logic buf_serial_en_out,
  input wire logic two_wire_interface_disable_out,
  input wire logic buf_rst_out,
  input wire logic buf_wr_out,
  input wire logic [7:0] buf_wdata_out
);
  import msdc_pkg::*;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  logic wr68;
  logic wr69;
  logic wr6a;
  // write decodes, kept outside the properties to keep them readable
  assign wr68 = reg_req_in.wr && reg_req_in.addr == `MSDC_PATH_RESET_CONTROL;
  assign wr69 = reg_req_in.wr && reg_req_in.addr == `MSDC_MOTION_DETECT_CONTROL;
  assign wr6a = reg_req_in.wr && reg_req_in.addr == `MSDC_HOST_CONTROL;
  read_answer_a: assert property (reg_req_in.rd |=> reg_rvalid_out)
    else $error("read not answered next cycle");
  no_stray_answer_a: assert property (reg_rvalid_out |-> $past(reg_req_in.rd))
    else $error("answer without a read");
  path_pulse_a: assert property (wr68 |=> accel_path_rst_out == $past(reg_req_in.wdata[1])
    && temp_path_rst_out == $past(reg_req_in.wdata[0]) && !rate_path_rst_out)
    else $error("path reset pulses wrong");
  full_reset_a: assert property (wr6a && reg_req_in.wdata[0] |=>
    accel_path_rst_out && temp_path_rst_out && rate_path_rst_out)
    else $error("full reset missed a path");
  motion_ctl_a: assert property (wr69 |=>
    motion_detect_enable_out == $past(reg_req_in.wdata[7])
    && motion_detect_mode_out == $past(reg_req_in.wdata[6]))
    else $error("motion control not taken");
  host_ctl_a: assert property (wr6a |=> buf_serial_en_out == $past(reg_req_in.wdata[6])
    && two_wire_interface_disable_out == $past(reg_req_in.wdata[4]))
    else $error("host control not taken");
  buf_reset_len_a: assert property (wr6a && reg_req_in.wdata[2] |=>
    buf_rst_out [*5] ##1 !buf_rst_out)
    else $error("buffer reset length wrong");
  mode_gate_a: assert property (!motion_detect_mode_out || !motion_detect_enable_out
    |=> !motion_detected_out)
    else $error("motion flagged while off");
  buf_first_byte_a: assert property (sample_valid_in && accel_buf_src_en_in && !buf_rst_out
    && !reg_req_in.wr ##1 !sample_valid_in && !buf_rst_out
    |=> buf_wr_out && buf_wdata_out == $past(sample_in.accel_x[15:8], 2))
    else $error("buffer stream head wrong");
endmodule
bind msdc_regs_top msdc_regs_chk u_chk (.ref_clk_in, .rst_n_in, .reg_req_in, .sample_in,
  .sample_valid_in, .accel_buf_src_en_in, .reg_rvalid_out, .accel_path_rst_out,
  .temp_path_rst_out, .rate_path_rst_out, .motion_detect_enable_out, .motion_detect_mode_out,
  .motion_detected_out, .buf_serial_en_out, .two_wire_interface_disable_out, .buf_rst_out,
  .buf_wr_out, .buf_wdata_out);

// [verilog/msdc_pkg.sv]
/*
  Types shared by the motion sensor register block and its bench.
  Assumes the constants of msdc_regs.svh for all numbers.
*/
package msdc_pkg;

  // one register access from the serial front end
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } msdc_reg_req_t;

  // one conversion result set, signed two's complement words
  typedef struct packed {
    logic [15:0] accel_x;
    logic [15:0] accel_y;
    logic [15:0] accel_z;
    logic [15:0] temp;
    logic [15:0] rate_x;
    logic [15:0] rate_y;
    logic [15:0] rate_z;
  } msdc_sample_t;

endpackage

// [verilog/msdc_regs.svh]
/*
  Offsets, field positions, reset values and timing counts of the motion
  sensor register block. Assumes 8-bit registers on an 8-bit register address.
*/
`ifndef MSDC_REGS_SVH
`define MSDC_REGS_SVH

// result window, upper byte first for each word
`define MSDC_ACCEL_X_HIGH_BYTE 8'h3B
`define MSDC_ACCEL_X_LOW_BYTE 8'h3C
`define MSDC_ACCEL_Y_HIGH_BYTE 8'h3D
`define MSDC_ACCEL_Y_LOW_BYTE 8'h3E
`define MSDC_ACCEL_Z_HIGH_BYTE 8'h3F
`define MSDC_ACCEL_Z_LOW_BYTE 8'h40
`define MSDC_TEMPERATURE_HIGH_BYTE 8'h41
`define MSDC_TEMPERATURE_LOW_BYTE 8'h42
`define MSDC_RATE_X_HIGH_BYTE 8'h43
`define MSDC_RATE_X_LOW_BYTE 8'h44
`define MSDC_RATE_Y_HIGH_BYTE 8'h45
`define MSDC_RATE_Y_LOW_BYTE 8'h46
`define MSDC_RATE_Z_HIGH_BYTE 8'h47
`define MSDC_RATE_Z_LOW_BYTE 8'h48
`define MSDC_RESULT_FIRST `MSDC_ACCEL_X_HIGH_BYTE
`define MSDC_RESULT_LAST `MSDC_RATE_Z_LOW_BYTE

// control registers
`define MSDC_PATH_RESET_CONTROL 8'h68
`define MSDC_MOTION_DETECT_CONTROL 8'h69
`define MSDC_HOST_CONTROL 8'h6A

// field positions
`define MSDC_ACCEL_PATH_RST_BIT 1
`define MSDC_TEMP_PATH_RST_BIT 0
`define MSDC_MOTION_DETECT_ENABLE_BIT 7
`define MSDC_MOTION_DETECT_MODE_BIT 6
`define MSDC_BUF_OP_EN_BIT 6
`define MSDC_TWO_WIRE_DIS_BIT 4
`define MSDC_BUF_RST_BIT 2
`define MSDC_FULL_COND_RST_BIT 0

// reset values
`define MSDC_MOTION_DETECT_CONTROL_RST 8'h00
`define MSDC_HOST_CONTROL_RST 8'h00
`define MSDC_RESULT_RST 16'h0000

// timing: buffer reset lasts one period of the 20 MHz internal clock
`define MSDC_REF_CLK_MHZ 100
`define MSDC_BUF_RST_NS 50
`define MSDC_BUF_RST_CYC ((`MSDC_BUF_RST_NS * `MSDC_REF_CLK_MHZ + 999) / 1000)

// nominal rate sensitivity at the lowest full-scale setting, counts per dps
`define MSDC_RATE_COUNTS_PER_DPS 131
// accel bytes written into the buffer per sample tick
`define MSDC_ACCEL_BUF_BYTES 6

`endif

// [verilog/msdc_regs_top.sv]
/*
  Register block of a six-axis motion sensor: result bytes, signal path
  resets, wake-on-motion control and host control.
  Assumes a serial front end on ref_clk_in that issues single-cycle register
  accesses, and conversion logic on the same clock presenting result sets.
*/
// Overview of operation
// - accel x, y, z results read as six bytes, upper byte first
// - temperature result reads as upper byte then lower byte
// - rate x, y, z results read as six bytes, upper byte first
// - rate words carry 131 counts per dps at lowest full scale
// - accel path reset pulses the accel path, results kept
// - temp path reset pulses the temp path, results kept
// - motion detect enable switches wake-on-motion logic on or off
// - mode one compares each accel sample to the previous; host never writes zero
// - buffer enable bit opens buffer mode; clear blocks serial buffer access
// - clearing buffer enable leaves internal accel buffer writes running
// - two-wire disable bit turns two-wire target off, SPI only
// - buffer reset bit resets the buffer module
// - buffer reset clears itself after one 20 MHz period
// - full conditioning reset pulses all three sensor paths
// - full conditioning reset also zeroes every result register
// - accel buffer source enable writes six accel bytes per sample tick
`timescale 1ns/1ns
`include "msdc_regs.svh"

module msdc_regs_top (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // register access from the serial front end
  input wire msdc_pkg::msdc_reg_req_t reg_req_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // conversion results and related inputs
  input wire msdc_pkg::msdc_sample_t sample_in,
  input wire logic sample_valid_in,
  input wire logic accel_buf_src_en_in,
  input wire logic [7:0] wom_threshold_in,
  // signal path control
  output logic accel_path_rst_out,
  output logic temp_path_rst_out,
  output logic rate_path_rst_out,
  // wake-on-motion
  output logic motion_detect_enable_out,
  output logic motion_detect_mode_out,
  output logic motion_detected_out,
  // host control
  output logic buf_serial_en_out,
  output logic two_wire_interface_disable_out,
  output logic buf_rst_out,
  // buffer write port
  output logic buf_wr_out,
  output logic [7:0] buf_wdata_out
);
  import msdc_pkg::*;

  localparam logic [3:0] BUF_RST_CYC = 4'(`MSDC_BUF_RST_CYC);
  localparam logic [2:0] ACC_BYTES = 3'(`MSDC_ACCEL_BUF_BYTES);

  // true when the address lies in the result window
  function automatic logic is_result(input logic [7:0] a);
    is_result = (a >= `MSDC_RESULT_FIRST) && (a <= `MSDC_RESULT_LAST);
  endfunction

  // word index of a result byte; even offsets are upper bytes
  function automatic logic [2:0] word_of(input logic [7:0] a);
    logic [7:0] off;
    off = a - `MSDC_RESULT_FIRST;
    word_of = off[3:1];
  endfunction

  function automatic logic is_high(input logic [7:0] a);
    logic [7:0] off;
    off = a - `MSDC_RESULT_FIRST;
    is_high = ~off[0];
  endfunction

  logic wr_ctl, wr_md, wr_host;
  assign wr_ctl = reg_req_in.wr && (reg_req_in.addr == `MSDC_PATH_RESET_CONTROL);
  assign wr_md = reg_req_in.wr && (reg_req_in.addr == `MSDC_MOTION_DETECT_CONTROL);
  assign wr_host = reg_req_in.wr && (reg_req_in.addr == `MSDC_HOST_CONTROL);

  // control group: stored bits and reset pulses
  logic md_en_q, md_en_d, md_mode_q, md_mode_d, buf_en_q, buf_en_d, tw_dis_q, tw_dis_d;
  logic acc_rst_q, acc_rst_d, tmp_rst_q, tmp_rst_d, rate_rst_q, rate_rst_d, brst_q, brst_d;
  logic [3:0] brst_cnt_q, brst_cnt_d;

  // reset bits are write-one pulses; only the buffer reset bit stays set, for BUF_RST_CYC cycles
  always_comb begin
    md_en_d = md_en_q;
    md_mode_d = md_mode_q;
    buf_en_d = buf_en_q;
    tw_dis_d = tw_dis_q;
    acc_rst_d = 1'b0;
    tmp_rst_d = 1'b0;
    rate_rst_d = 1'b0;
    brst_cnt_d = (brst_cnt_q != 4'h0) ? brst_cnt_q - 4'h1 : 4'h0;
    if (wr_ctl) begin
      acc_rst_d = reg_req_in.wdata[`MSDC_ACCEL_PATH_RST_BIT];
      tmp_rst_d = reg_req_in.wdata[`MSDC_TEMP_PATH_RST_BIT];
    end
    if (wr_md) begin
      md_en_d = reg_req_in.wdata[`MSDC_MOTION_DETECT_ENABLE_BIT];
      md_mode_d = reg_req_in.wdata[`MSDC_MOTION_DETECT_MODE_BIT];
    end
    if (wr_host) begin
      buf_en_d = reg_req_in.wdata[`MSDC_BUF_OP_EN_BIT];
      tw_dis_d = reg_req_in.wdata[`MSDC_TWO_WIRE_DIS_BIT];
      if (reg_req_in.wdata[`MSDC_BUF_RST_BIT]) begin
        brst_cnt_d = BUF_RST_CYC;
      end
      if (reg_req_in.wdata[`MSDC_FULL_COND_RST_BIT]) begin
        acc_rst_d = 1'b1;
        tmp_rst_d = 1'b1;
        rate_rst_d = 1'b1;
      end
    end
    brst_d = (brst_cnt_d != 4'h0);
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      md_en_q <= 1'(`MSDC_MOTION_DETECT_CONTROL_RST >> `MSDC_MOTION_DETECT_ENABLE_BIT);
      md_mode_q <= 1'(`MSDC_MOTION_DETECT_CONTROL_RST >> `MSDC_MOTION_DETECT_MODE_BIT);
      buf_en_q <= 1'(`MSDC_HOST_CONTROL_RST >> `MSDC_BUF_OP_EN_BIT);
      tw_dis_q <= 1'(`MSDC_HOST_CONTROL_RST >> `MSDC_TWO_WIRE_DIS_BIT);
      acc_rst_q <= 1'b0;
      tmp_rst_q <= 1'b0;
      rate_rst_q <= 1'b0;
      brst_cnt_q <= 4'h0;
      brst_q <= 1'b0;
    end else begin
      md_en_q <= md_en_d;
      md_mode_q <= md_mode_d;
      buf_en_q <= buf_en_d;
      tw_dis_q <= tw_dis_d;
      acc_rst_q <= acc_rst_d;
      tmp_rst_q <= tmp_rst_d;
      rate_rst_q <= rate_rst_d;
      brst_cnt_q <= brst_cnt_d;
      brst_q <= brst_d;
    end
  end

  // full conditioning reset as seen in the write cycle
  logic cond_rst;
  assign cond_rst = wr_host && reg_req_in.wdata[`MSDC_FULL_COND_RST_BIT];

  // result group: whole sets captured at once so a pair never mixes sets
  logic [15:0] res_q [7], res_d [7], smp_w [7];
  assign smp_w[0] = sample_in.accel_x;
  assign smp_w[1] = sample_in.accel_y;
  assign smp_w[2] = sample_in.accel_z;
  assign smp_w[3] = sample_in.temp;
  assign smp_w[4] = sample_in.rate_x;
  assign smp_w[5] = sample_in.rate_y;
  assign smp_w[6] = sample_in.rate_z;

  // clearing wins over a sample landing in the same cycle
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      res_d[i] = res_q[i];
      if (cond_rst) begin
        res_d[i] = `MSDC_RESULT_RST;
      end else if (sample_valid_in) begin
        res_d[i] = smp_w[i];
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      res_q <= '{default: `MSDC_RESULT_RST};
    end else begin
      res_q <= res_d;
    end
  end

  // read group: lower byte is held from the moment its upper byte is read
  logic [7:0] rdata_q, rdata_d, shadow_q, shadow_d;
  logic rvalid_q, rvalid_d, shadow_ok_q, shadow_ok_d;
  logic [2:0] shadow_w_q, shadow_w_d;
  logic [2:0] rw;
  assign rw = word_of(reg_req_in.addr);

  always_comb begin
    rdata_d = 8'h00;
    rvalid_d = reg_req_in.rd;
    shadow_d = shadow_q;
    shadow_w_d = shadow_w_q;
    shadow_ok_d = shadow_ok_q && !cond_rst;
    if (reg_req_in.rd) begin
      if (is_result(reg_req_in.addr)) begin
        if (is_high(reg_req_in.addr)) begin
          rdata_d = res_q[rw][15:8];
          shadow_d = res_q[rw][7:0];
          shadow_w_d = rw;
          shadow_ok_d = 1'b1;
        end else if (shadow_ok_q && shadow_w_q == rw) begin
          rdata_d = shadow_q;
          shadow_ok_d = 1'b0;
        end else begin
          rdata_d = res_q[rw][7:0];
        end
      end else begin
        case (reg_req_in.addr)
          `MSDC_MOTION_DETECT_CONTROL: begin
            rdata_d = {md_en_q, md_mode_q, 6'h00};
          end
          `MSDC_HOST_CONTROL: begin
            rdata_d = {1'b0, buf_en_q, 1'b0, tw_dis_q, 1'b0, brst_q, 2'h0};
          end
          default: begin
            rdata_d = 8'h00; // path reset bits read back zero
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
      shadow_q <= 8'h00;
      shadow_w_q <= 3'h0;
      shadow_ok_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      shadow_q <= shadow_d;
      shadow_w_q <= shadow_w_d;
      shadow_ok_q <= shadow_ok_d;
    end
  end
  // wake-on-motion group: per-axis change against the previous sample
  logic [15:0] prev_q [3], prev_d [3];
  logic prev_ok_q, prev_ok_d, wom_q, wom_d;
  logic [2:0] over;

  // threshold is compared against the upper byte of the change magnitude
  generate
    for (genvar g = 0; g < 3; g++) begin : g_axis
      logic [16:0] diff, mag;
      assign diff = {smp_w[g][15], smp_w[g]} - {prev_q[g][15], prev_q[g]};
      assign mag = diff[16] ? 17'(~diff + 17'h00001) : diff;
      assign over[g] = mag > {1'b0, wom_threshold_in, 8'hFF};
    end
  endgenerate

  always_comb begin
    prev_ok_d = prev_ok_q;
    wom_d = 1'b0;
    prev_d = prev_q;
    if (acc_rst_q || !md_en_q) begin
      prev_ok_d = 1'b0;
    end else if (sample_valid_in) begin
      // a zero mode bit is a forbidden setting, so no comparison runs
      wom_d = md_mode_q && prev_ok_q && (over != 3'h0);
      prev_ok_d = 1'b1;
      for (int i = 0; i < 3; i++) begin
        prev_d[i] = smp_w[i];
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      prev_ok_q <= 1'b0;
      wom_q <= 1'b0;
      prev_q <= '{default: 16'h0000};
    end else begin
      prev_ok_q <= prev_ok_d;
      wom_q <= wom_d;
      prev_q <= prev_d;
    end
  end
  // buffer group: six accel bytes streamed one per cycle after a tick
  logic [47:0] bsnap_q, bsnap_d;
  logic [2:0] bcnt_q, bcnt_d;
  logic bwr_q, bwr_d;
  logic [7:0] bdata_q, bdata_d;

  // independent of the buffer enable bit; a buffer reset drops the stream
  always_comb begin
    bsnap_d = bsnap_q;
    bcnt_d = bcnt_q;
    bwr_d = 1'b0;
    bdata_d = bdata_q;
    if (brst_q) begin
      bcnt_d = 3'h0;
    end else if (sample_valid_in && accel_buf_src_en_in) begin
      bsnap_d = {sample_in.accel_x, sample_in.accel_y, sample_in.accel_z};
      bcnt_d = ACC_BYTES;
    end else if (bcnt_q != 3'h0) begin
      bwr_d = 1'b1;
      bdata_d = bsnap_q[47:40];
      bsnap_d = {bsnap_q[39:0], 8'h00};
      bcnt_d = bcnt_q - 3'h1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      bsnap_q <= 48'h000000000000;
      bcnt_q <= 3'h0;
      bwr_q <= 1'b0;
      bdata_q <= 8'h00;
    end else begin
      bsnap_q <= bsnap_d;
      bcnt_q <= bcnt_d;
      bwr_q <= bwr_d;
      bdata_q <= bdata_d;
    end
  end

  // all outputs straight from flops
  assign reg_rdata_out = rdata_q;
  assign reg_rvalid_out = rvalid_q;
  assign accel_path_rst_out = acc_rst_q;
  assign temp_path_rst_out = tmp_rst_q;
  assign rate_path_rst_out = rate_rst_q;
  assign motion_detect_enable_out = md_en_q;
  assign motion_detect_mode_out = md_mode_q;
  assign motion_detected_out = wom_q;
  assign buf_serial_en_out = buf_en_q;
  assign two_wire_interface_disable_out = tw_dis_q;
  assign buf_rst_out = brst_q;
  assign buf_wr_out = bwr_q;
  assign buf_wdata_out = bdata_q;

endmodule
